// ---- src/pte_top.sv ----
// pulse-train engine: sixteen pattern/square generators behind an APB slave
// Functional notes
// - Sixteen generators, each with own enable, mode and rate settings.
// - Output is square wave or repeating pattern of 2 to 32 bits.
// - Each generator's rate is set separately from the others.
// - Rate is module clock divided by a selectable power of two.
// - Restart of any set returns all named generators that are enabled to bit zero together; disabled ones stay off.
// - Single-shot mode emits the pattern once then stops; in square mode it keeps toggling.
module pte_top
	import pte_pkg::*;
#(
	parameter int unsigned NUM_GEN = pte_pkg::PTE_NUM_GEN
) (
	input  wire logic               pclk,      // module clock
	input  wire logic               presetn,   // async reset, active low
	input  wire logic               psel,      // apb select
	input  wire logic               penable,   // apb access phase
	input  wire logic               pwrite,    // apb direction
	input  wire logic [11:0]        paddr,     // apb byte address
	input  wire logic [31:0]        pwdata,    // apb write data
	output logic      [31:0]        prdata,    // apb read data
	output logic                    pready,    // apb ready
	output logic                    pslverr,   // apb error, unmapped address
	output logic      [NUM_GEN-1:0] pt_out     // pulse-train outputs
);
	import pte_pkg::*;

	// ==========================================================
	// register state
	logic [NUM_GEN-1:0] en_ff, nxt_en;
	logic [NUM_GEN-1:0] rst_pulse;
	pte_cfg_t           cfg_ff [NUM_GEN];
	pte_cfg_t           nxt_cfg [NUM_GEN];
	logic [NUM_GEN-1:0] run_ff, nxt_run;
	logic [NUM_GEN-1:0] out_ff, nxt_out;
	logic [PTE_LEN_W-1:0] pos_ff [NUM_GEN];
	logic [PTE_LEN_W-1:0] nxt_pos [NUM_GEN];
	logic [PTE_CNT_W-1:0] cnt_ff [NUM_GEN];
	logic [PTE_CNT_W-1:0] nxt_cnt [NUM_GEN];
	logic [31:0]        prdata_ff, nxt_prdata;
	logic               err_ff, nxt_err;

	logic       wr_en;
	logic       rd_en;
	logic       gen_hit;
	logic [3:0] gen_idx;
	logic [3:0] sub_ofs;

	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & ~penable & ~pwrite; // setup phase of a read
	assign gen_hit = (paddr >= PTE_OFS_GEN0)
		&& (paddr < PTE_OFS_GEN0 + 12'(NUM_GEN) * PTE_GEN_STRIDE);
	assign gen_idx = 4'((paddr - PTE_OFS_GEN0) >> 4);
	assign sub_ofs = paddr[3:0];
	// zero-wait slave: answers in the first access cycle
	// read data and error are latched at the setup edge so they stand with pready
	assign pready  = psel & penable;
	assign prdata  = prdata_ff;
	assign pslverr = err_ff;
	assign pt_out  = out_ff;

	// ==========================================================
	// register writes, restart strobe and read mux
	always_comb begin
		logic        mapped;
		logic [31:0] rd;
		mapped     = 1'b0;
		rd         = 32'h0000_0000;
		nxt_en     = en_ff;
		rst_pulse  = '0;
		nxt_prdata = prdata_ff;
		nxt_err    = 1'b0;
		for (int g = 0; g < NUM_GEN; g++) begin
			nxt_cfg[g] = cfg_ff[g];
		end
		case (paddr)
			PTE_OFS_ENABLE: begin
				mapped = 1'b1;
				rd     = 32'(en_ff);
			end
			PTE_OFS_RESTART: begin
				mapped = 1'b1;
			end
			PTE_OFS_ACTIVE: begin
				mapped = 1'b1;
				rd     = 32'(run_ff);
			end
			default: begin
				if (gen_hit && sub_ofs == PTE_SUB_CFG) begin
					mapped = 1'b1;
					rd = 32'(cfg_ff[gen_idx].pat_mode) << PTE_CFG_MODE_BIT
						| 32'(cfg_ff[gen_idx].once) << PTE_CFG_ONCE_BIT
						| 32'(cfg_ff[gen_idx].len_m1) << PTE_CFG_LEN_LSB
						| 32'(cfg_ff[gen_idx].div_sel) << PTE_CFG_DIV_LSB;
				end else if (gen_hit && sub_ofs == PTE_SUB_PAT) begin
					mapped = 1'b1;
					rd     = cfg_ff[gen_idx].pattern;
				end
			end
		endcase
		// error latched in setup, high only through the access cycle
		if (psel && !penable) begin
			nxt_err = ~mapped;
		end
		if (rd_en) begin
			nxt_prdata = rd;
		end
		if (wr_en && mapped) begin
			if (paddr == PTE_OFS_ENABLE) begin
				nxt_en = pwdata[NUM_GEN-1:0];
			end else if (paddr == PTE_OFS_RESTART) begin
				rst_pulse = pwdata[NUM_GEN-1:0];
			end else if (sub_ofs == PTE_SUB_CFG) begin
				nxt_cfg[gen_idx].pat_mode = pwdata[PTE_CFG_MODE_BIT];
				nxt_cfg[gen_idx].once     = pwdata[PTE_CFG_ONCE_BIT];
				nxt_cfg[gen_idx].div_sel  = pwdata[PTE_CFG_DIV_LSB +: PTE_DIV_W];
				// shortest pattern is two bits
				nxt_cfg[gen_idx].len_m1 = (pwdata[PTE_CFG_LEN_LSB +: PTE_LEN_W] == '0)
					? PTE_LEN_W'(1) : pwdata[PTE_CFG_LEN_LSB +: PTE_LEN_W];
			end else if (sub_ofs == PTE_SUB_PAT) begin
				nxt_cfg[gen_idx].pattern = pwdata;
			end
		end
	end

	// ==========================================================
	// generator sequencing
	always_comb begin
		logic [PTE_CNT_W-1:0] term;
		term = '0;
		for (int g = 0; g < NUM_GEN; g++) begin
			term       = PTE_CNT_W'((32'd2 << cfg_ff[g].div_sel) - 32'd1);
			nxt_cnt[g] = cnt_ff[g];
			nxt_pos[g] = pos_ff[g];
			nxt_run[g] = run_ff[g];
			nxt_out[g] = out_ff[g];
			if (!en_ff[g]) begin
				nxt_cnt[g] = '0;
				nxt_pos[g] = '0;
				nxt_run[g] = 1'b0;
				nxt_out[g] = 1'b0;
			end else if (rst_pulse[g] || (nxt_en[g] && !run_ff[g] && !cfg_ff[g].once)) begin
				// named generators all start at bit zero on the same edge
				nxt_cnt[g] = '0;
				nxt_pos[g] = '0;
				nxt_run[g] = 1'b1;
				nxt_out[g] = cfg_ff[g].pat_mode ? cfg_ff[g].pattern[0] : 1'b1;
			end else if (run_ff[g]) begin
				if (cnt_ff[g] >= term) begin
					nxt_cnt[g] = '0;
					if (!cfg_ff[g].pat_mode) begin
						nxt_out[g] = ~out_ff[g];
					end else if (pos_ff[g] == cfg_ff[g].len_m1) begin
						nxt_pos[g] = '0;
						if (cfg_ff[g].once) begin
							nxt_run[g] = 1'b0;
							nxt_out[g] = 1'b0;
						end else begin
							nxt_out[g] = cfg_ff[g].pattern[0];
						end
					end else begin
						nxt_pos[g] = pos_ff[g] + PTE_LEN_W'(1);
						nxt_out[g] = cfg_ff[g].pattern[pos_ff[g] + PTE_LEN_W'(1)];
					end
				end else begin
					nxt_cnt[g] = cnt_ff[g] + PTE_CNT_W'(1);
				end
			end
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_ff     <= '0;
			run_ff    <= '0;
			out_ff    <= '0;
			prdata_ff <= 32'h0000_0000;
			err_ff    <= 1'b0;
			for (int g = 0; g < NUM_GEN; g++) begin
				cfg_ff[g] <= '{pat_mode: PTE_RST_CFG[PTE_CFG_MODE_BIT],
					once: PTE_RST_CFG[PTE_CFG_ONCE_BIT],
					len_m1: PTE_RST_CFG[PTE_CFG_LEN_LSB +: PTE_LEN_W],
					div_sel: PTE_RST_CFG[PTE_CFG_DIV_LSB +: PTE_DIV_W],
					pattern: PTE_RST_PAT};
				pos_ff[g] <= '0;
				cnt_ff[g] <= '0;
			end
		end else begin
			en_ff     <= nxt_en;
			run_ff    <= nxt_run;
			out_ff    <= nxt_out;
			prdata_ff <= nxt_prdata;
			err_ff    <= nxt_err;
			for (int g = 0; g < NUM_GEN; g++) begin
				cfg_ff[g] <= nxt_cfg[g];
				pos_ff[g] <= nxt_pos[g];
				cnt_ff[g] <= nxt_cnt[g];
			end
		end
	end

	// ==========================================================
	// checks
	property p_enable_write;
		@(posedge pclk) disable iff (!presetn)
		wr_en && paddr == PTE_OFS_ENABLE |=> en_ff == $past(pwdata[NUM_GEN-1:0]);
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable not stored");

	property p_disabled_low;
		@(posedge pclk) disable iff (!presetn)
		!en_ff[0] |=> !out_ff[0] && !run_ff[0];
	endproperty
	a_disabled_low: assert property (p_disabled_low) else $error("idle output not low");

	property p_len_min;
		@(posedge pclk) disable iff (!presetn)
		cfg_ff[0].len_m1 != '0;
	endproperty
	a_len_min: assert property (p_len_min) else $error("pattern shorter than two");

	property p_div_hold;
		@(posedge pclk) disable iff (!presetn)
		run_ff[1] && en_ff[1] && !rst_pulse[1] && cnt_ff[1] != '0 |-> out_ff[1] == $past(out_ff[1]);
	endproperty
	a_div_hold: assert property (p_div_hold) else $error("output moved mid period");

	property p_div_bound;
		@(posedge pclk) disable iff (!presetn)
		cnt_ff[0] <= PTE_CNT_W'((32'd2 << cfg_ff[0].div_sel) - 32'd1);
	endproperty
	a_div_bound: assert property (p_div_bound) else $error("divider overran");

	property p_restart;
		@(posedge pclk) disable iff (!presetn)
		rst_pulse[0] && rst_pulse[1] && en_ff[0] && en_ff[1]
			|=> pos_ff[0] == '0 && pos_ff[1] == '0 && cnt_ff[0] == cnt_ff[1];
	endproperty
	a_restart: assert property (p_restart) else $error("restart not in step");

	property p_once_stop;
		@(posedge pclk) disable iff (!presetn)
		run_ff[0] && cfg_ff[0].once && cfg_ff[0].pat_mode && nxt_pos[0] == '0
			&& pos_ff[0] == cfg_ff[0].len_m1 && !rst_pulse[0] && en_ff[0]
			&& cnt_ff[0] >= PTE_CNT_W'((32'd2 << cfg_ff[0].div_sel) - 32'd1) |=> !run_ff[0];
	endproperty
	a_once_stop: assert property (p_once_stop) else $error("single shot kept running");

	property p_square_toggle;
		@(posedge pclk) disable iff (!presetn)
		run_ff[0] && en_ff[0] && !rst_pulse[0] && !cfg_ff[0].pat_mode
			&& cnt_ff[0] >= PTE_CNT_W'((32'd2 << cfg_ff[0].div_sel) - 32'd1)
			|=> out_ff[0] != $past(out_ff[0]);
	endproperty
	a_square_toggle: assert property (p_square_toggle) else $error("square did not toggle");
endmodule : pte_top

// ---- pkg/pte_pkg.sv ----
// package for the pulse-train engine: register map, field layout, reset values
package pte_pkg;
	// ==========================================================
	// sizes
	localparam int unsigned PTE_NUM_GEN   = 16;
	localparam int unsigned PTE_PAT_W     = 32;
	localparam int unsigned PTE_LEN_W     = 5;   // length minus one
	localparam int unsigned PTE_DIV_W     = 4;   // divide by 2**(sel+1)
	localparam int unsigned PTE_CNT_W     = 16;
	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [11:0] PTE_OFS_ENABLE  = 12'h000;
	localparam logic [11:0] PTE_OFS_RESTART = 12'h004;
	localparam logic [11:0] PTE_OFS_ACTIVE  = 12'h008;
	localparam logic [11:0] PTE_OFS_GEN0    = 12'h040; // per-generator block base
	localparam logic [11:0] PTE_GEN_STRIDE  = 12'h010;
	localparam logic [3:0]  PTE_SUB_CFG     = 4'h0;
	localparam logic [3:0]  PTE_SUB_PAT     = 4'h4;
	// ==========================================================
	// config word fields
	localparam int unsigned PTE_CFG_MODE_BIT = 0;   // 1 = pattern, 0 = square
	localparam int unsigned PTE_CFG_ONCE_BIT = 1;   // single-shot
	localparam int unsigned PTE_CFG_LEN_LSB  = 8;
	localparam int unsigned PTE_CFG_DIV_LSB  = 16;
	// ==========================================================
	// reset values
	localparam logic [31:0] PTE_RST_CFG   = 32'h0000_1F00;
	localparam logic [31:0] PTE_RST_PAT   = 32'h0000_0000;
	// ==========================================================
	// per-generator settings carried together
	typedef struct packed {
		logic                 pat_mode;
		logic                 once;
		logic [PTE_LEN_W-1:0] len_m1;
		logic [PTE_DIV_W-1:0] div_sel;
		logic [PTE_PAT_W-1:0] pattern;
	} pte_cfg_t;
endpackage : pte_pkg

// ---- verification/test_pulse_train_engine.sv ----
// bench for the pulse-train engine: registers, trains, restart, single shot
module test_pulse_train_engine;
	timeunit 1ns;
	timeprecision 1ns;
	import pte_pkg::*;
	// ==========================================================
	// signals and table
	typedef struct packed {
		logic        w;
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] rd;
		logic        err;
	} pte_row_t;
	localparam pte_row_t ROWS [10] = '{
		'{1'b0, PTE_OFS_ENABLE, 32'h0, 32'h0, 1'b0},
		'{1'b0, PTE_OFS_ACTIVE, 32'h0, 32'h0, 1'b0},
		'{1'b0, PTE_OFS_RESTART, 32'h0, 32'h0, 1'b0},
		'{1'b0, 12'h040, 32'h0, PTE_RST_CFG, 1'b0},
		'{1'b0, 12'h134, 32'h0, PTE_RST_PAT, 1'b0},
		'{1'b1, 12'h044, 32'hA5, 32'h0, 1'b0},
		'{1'b0, 12'h044, 32'h0, 32'hA5, 1'b0},
		'{1'b0, 12'h00C, 32'h0, 32'h0, 1'b1},
		'{1'b1, 12'h138, 32'h5, 32'h0, 1'b1},
		'{1'b0, 12'h138, 32'h0, 32'h0, 1'b1}};
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [15:0] pt_out;
	int          n_fail = 0;
	int          tests_run = 0;

	// clock
	initial pclk = 1'b0;
	always #25 pclk = ~pclk;

	pte_top #(.NUM_GEN(16)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pt_out(pt_out));
	// ==========================================================
	// compare, bus and train tasks
	task cmp32(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: word %h expected %h", $time, got, exp);
		end
	endtask : cmp32
	task cmp1(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: bit %b expected %b", $time, got, exp);
		end
	endtask : cmp1
	// one apb transfer; read data and error taken at the ready edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rdat = prdata;
		rerr = pslverr;
		if (k >= 20) n_fail++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// find bit 0 high, then check one bit per period
	task train(input int g, input logic [31:0] pat, input int len, input int per,
		input int nb, input logic once);
		int k;
		k = 0;
		while (pt_out[g] !== 1'b1 && k < 8) begin
			@(negedge pclk);
			k++;
		end
		cmp1(pt_out[g], 1'b1);
		for (int i = 1; i < nb; i++) begin
			repeat (per) @(negedge pclk);
			cmp1(pt_out[g], (once && i >= len) ? 1'b0 : pat[i % len]);
		end
	endtask : train
	task results;
		if (n_fail == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : results
	// ==========================================================
	// main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (4) @(posedge pclk);
		cmp32({16'h0, pt_out}, 32'h0);
		presetn <= 1'b1;
		foreach (ROWS[i]) begin
			apb(ROWS[i].w, ROWS[i].a, ROWS[i].d);
			cmp1(rerr, ROWS[i].err);
			if (!ROWS[i].w && !ROWS[i].err) cmp32(rdat, ROWS[i].rd);
		end
		// pattern gen0 at divide 2, square gen1 at divide 4
		apb(1'b1, 12'h040, 32'h0000_0701);
		apb(1'b1, PTE_OFS_ENABLE, 32'h1);
		train(0, 32'hA5, 8, 2, 17, 1'b0);
		apb(1'b1, 12'h050, 32'h0001_0000);
		apb(1'b1, PTE_OFS_ENABLE, 32'h3);
		train(1, 32'h1, 2, 4, 9, 1'b0);
		// gen2 and gen3 started apart, then restarted together
		for (int g = 2; g < 4; g++) begin
			apb(1'b1, 12'(12'h040 + 16 * g), 32'h0002_1F01);
			apb(1'b1, 12'(12'h044 + 16 * g), 32'h0000_A5C3);
		end
		apb(1'b1, PTE_OFS_ENABLE, 32'h7);
		repeat (2) @(posedge pclk);
		apb(1'b1, PTE_OFS_ENABLE, 32'hF);
		apb(1'b1, PTE_OFS_RESTART, 32'hF);
		repeat (2) @(negedge pclk);
		repeat (40) begin
			cmp1(pt_out[3], pt_out[2]);
			@(negedge pclk);
		end
		// single shot gen4 with length field 0
		apb(1'b1, 12'h080, 32'h0000_0003);
		apb(1'b1, 12'h084, 32'h1);
		apb(1'b0, 12'h080, 32'h0);
		cmp32(rdat, 32'h0000_0103);
		apb(1'b1, PTE_OFS_ENABLE, 32'h1F);
		apb(1'b1, PTE_OFS_RESTART, 32'h10);
		train(4, 32'h1, 2, 2, 8, 1'b1);
		apb(1'b1, PTE_OFS_ACTIVE, 32'hFFFF);
		apb(1'b0, PTE_OFS_ACTIVE, 32'h0);
		cmp32(rdat, 32'h0000_000F);
		// gen0 turned single shot, two bits of its pattern
		apb(1'b1, 12'h040, 32'h0000_0103);
		apb(1'b1, PTE_OFS_RESTART, 32'h1);
		train(0, 32'hA5, 2, 2, 6, 1'b1);
		apb(1'b0, PTE_OFS_ACTIVE, 32'h0);
		cmp32(rdat, 32'h0000_000E);
		// reset in mid-run
		@(posedge pclk);
		presetn <= 1'b0;
		@(negedge pclk);
		cmp32({16'h0, pt_out}, 32'h0);
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, PTE_OFS_ENABLE, 32'h0);
		cmp32(rdat, 32'h0);
		// after reset gen0 is square at divide 2, starting high
		apb(1'b1, PTE_OFS_ENABLE, 32'h1);
		train(0, 32'h1, 2, 2, 6, 1'b0);
		results();
	end

	// watchdog
	initial begin
		repeat (3000) @(posedge pclk);
		n_fail++;
		results();
	end
endmodule : test_pulse_train_engine
